// ### pkg/sacc_pkg.sv
// Shared constants and carrier types for the converter control block
package sacc_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_INSEL = 8'h08;
	localparam logic [7:0] OFF_RES_LOW = 8'h0c;
	localparam logic [7:0] OFF_RES_HIGH = 8'h10;
	// control_status_a_reg fields
	localparam int CA_ENABLE = 7;
	localparam int CA_START = 6;
	localparam int CA_AUTO = 5;
	localparam int CA_DONE = 4;
	localparam int CA_DIV_LSB = 0;
	// control_status_b_reg field
	localparam int CB_TRIG_LSB = 0;
	// input_select_reg fields
	localparam int IS_REF_LSB = 6;
	localparam int IS_LEFT = 5;
	localparam int IS_CHAN_LSB = 0;
	localparam int IS_DIFF = 4;
	// Reset values
	localparam logic [7:0] RST_CTRL_A = 8'h00;
	localparam logic [2:0] RST_CTRL_B = 3'h0;
	localparam logic [7:0] RST_INSEL = 8'h00;
	// Timing in converter clock cycles; TRIG_SYNC_CYC in mclk cycles, MIN_CPU_KHZ in kHz
	localparam logic [4:0] CYC_NORMAL = 5'h0d;
	localparam logic [4:0] CYC_DIFF_LONG = 5'h0e;
	localparam logic [4:0] CYC_FIRST = 5'h19;
	localparam logic [4:0] SH_NORMAL = 5'h01;
	localparam logic [4:0] SH_FIRST = 5'h0d;
	localparam logic [4:0] SH_AUTO = 5'h02;
	localparam int TRIG_SYNC_CYC = 3;
	localparam int MIN_CPU_KHZ = 100;
	// Trigger select code that means the done flag itself
	localparam logic [2:0] TRIG_DONE_FLAG = 3'h0;

	// Selection that reaches the analog core
	typedef struct packed {
		logic [1:0] ref_sel;
		logic [4:0] channel;
	} sacc_sel_s;

	// Strobes and status towards the analog core
	typedef struct packed {
		logic active;
		logic sample_hold;
		logic conv_clock;
		logic half_rate_conv_clock;
	} sacc_core_s;
endpackage : sacc_pkg

// ### design/sacc_ctrl.sv
// Conversion control for a 10-bit successive-approximation converter
// Behaviour
// RL1: Selections reach the converter only once the enable bit is set.
// RL2: Result spans two bytes, right adjusted unless left-adjust is selected.
// RL3: Reading low byte locks result until high byte read; later results dropped.
// RL4: Done flag still sets when a finished result is dropped by the lock.
// RL5: Start bit begins a conversion, reads one throughout, clears at single completion.
// RL6: Channel change during conversion applies only after it finishes.
// RL7: Auto-trigger rising edge resets the prescaler and starts a conversion.
// RL8: Trigger held high at completion or edges during conversion start nothing.
// RL9: Software clears the trigger source flag before its next event can start.
// RL10: Done flag as trigger source runs continuously, regardless of flag clearing.
// RL11: Prescaler runs while enabled and is held in reset while disabled.
// RL12: Divider select field chooses prescale ratio for any clock above 100 kHz.
// RL13: Software-started conversion begins at next rising converter clock edge.
// RL14: Normal conversion takes 13 cycles; first after enabling takes 25.
// RL15: Sample-and-hold at 1.5 cycles normally, later on the first conversion.
// RL16: Completion writes result, sets flag, clears start bit in one cycle.
// RL17: Auto-triggered sample 2 cycles after edge, three sync clocks, 13.5 total. Sample here comes 3 cycles after the start.
// RL18: Free-running restarts at once on completion and leaves start bit set.
// RL19: Software start still works while auto-triggering is enabled.
// RL20: Differential conversions align to half-rate clock: 13 or 14 cycles.
// RL21: Software toggles enable between differential auto-triggered conversions.
// RL22: Selection copy locks at start and tracks again in the last cycle.
// RL23: Divider and trigger select encodings are implementation parameters.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sacc_ctrl
#(
	parameter int NUM_TRIG = 8,
	parameter int RES_W = 10
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger sources, index 0 is unused (done flag)
	input wire logic [NUM_TRIG-1:0] trig_in,
	// Analog core
	input wire logic [RES_W-1:0] core_result,
	output sacc_pkg::sacc_sel_s core_sel,
	output sacc_pkg::sacc_core_s core_ctl,
	output logic conv_done_irq
);
	import sacc_pkg::*;

	typedef enum logic {SACC_IDLE, SACC_CONV} sacc_state_e;

	// Elaboration checks: the trigger index is three bits and the placement is 10-bit only
	if (NUM_TRIG < 2 || NUM_TRIG > 8)
	begin : g_bad_trig
		$error("NUM_TRIG must be 2..8");
	end
	if (RES_W != 10)
	begin : g_bad_res
		$error("RES_W must be 10");
	end

	// Half period of the converter clock in mclk cycles for a divider code
	// RL23: divider code encoding
	function automatic logic [7:0] sacc_half(input logic [2:0] sel);
		sacc_half = 8'h01 << sel;
	endfunction : sacc_half

	// Result placement in a 16-bit pair, high byte in [15:8]
	function automatic logic [15:0] sacc_place(input logic [9:0] r, input logic left);
		sacc_place = left ? {r, 6'h00} : {6'h00, r};
	endfunction : sacc_place

	// Software-visible state
	logic converter_enable;
	logic start_conversion_bit;
	logic auto_trigger_enable;
	logic conversion_done_flag;
	logic [2:0] clock_divider_select;
	logic [2:0] trigger_source_select;
	logic [7:0] input_select_reg;
	logic [7:0] result_high_byte;
	logic [7:0] result_low_byte;
	logic res_lock;
	// Conversion state
	sacc_state_e state;
	logic [7:0] pre_cnt;
	logic half_rate_conv_clock;
	logic [4:0] conv_cnt;
	logic [4:0] conv_len;
	logic conv_first;
	logic conv_auto;
	logic first_pend;
	logic start_req;
	logic pre_reset_seen;
	logic trig_prev;
	logic [TRIG_SYNC_CYC-1:0] trig_pipe;
	logic ack;
	sacc_sel_s held_sel;

	// Bus decode
	logic acc;
	logic xfer;
	logic wr_a;
	logic wr_b;
	logic wr_sel;
	logic rd_low;
	logic rd_high;
	logic mapped;
	assign acc = psel && penable;
	assign pready = acc && ack;
	assign xfer = acc && ack;
	assign mapped = paddr == OFF_CTRL_A || paddr == OFF_CTRL_B || paddr == OFF_INSEL
		|| paddr == OFF_RES_LOW || paddr == OFF_RES_HIGH;
	assign pslverr = pready && !mapped;
	assign wr_a = xfer && pwrite && paddr == OFF_CTRL_A;
	assign wr_b = xfer && pwrite && paddr == OFF_CTRL_B;
	assign wr_sel = xfer && pwrite && paddr == OFF_INSEL;
	assign rd_low = xfer && !pwrite && paddr == OFF_RES_LOW;
	assign rd_high = xfer && !pwrite && paddr == OFF_RES_HIGH;

	// One wait state so read data comes from a flop
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			ack <= 1'b0;
		else
			ack <= acc && !ack;
	end

	// Read data captured in the first access cycle
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			prdata <= 32'h0;
		else if (acc && !ack)
		begin
			case (paddr)
				OFF_CTRL_A: prdata <= {24'h0, converter_enable, start_conversion_bit,
					auto_trigger_enable, conversion_done_flag, 1'b0, clock_divider_select};
				OFF_CTRL_B: prdata <= {29'h0, trigger_source_select};
				OFF_INSEL: prdata <= {24'h0, input_select_reg};
				OFF_RES_LOW: prdata <= {24'h0, result_low_byte};
				OFF_RES_HIGH: prdata <= {24'h0, result_high_byte};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// Prescaler ticks: rise at count zero, fall at half period
	logic [7:0] half;
	logic [7:0] full_m1;
	logic rise;
	logic fall;
	logic pre_reset;
	assign half = sacc_half(clock_divider_select);
	assign full_m1 = 8'((9'(half) << 1) - 9'h1);
	assign rise = converter_enable && !pre_reset && pre_cnt == 8'h0;
	assign fall = converter_enable && !pre_reset && pre_cnt == half;

	// RL11: prescaler held while disabled
	// RL12: ratio chosen by divider select
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			pre_cnt <= 8'h0;
		else if (!converter_enable || pre_reset)
			pre_cnt <= 8'h0;
		else if (pre_cnt >= full_m1)
			pre_cnt <= 8'h0;
		else
			pre_cnt <= pre_cnt + 8'h1;
	end

	// Half-rate clock toggles on each converter clock rise
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			half_rate_conv_clock <= 1'b0;
		else if (!converter_enable || pre_reset)
			half_rate_conv_clock <= 1'b0;
		else if (rise)
			half_rate_conv_clock <= !half_rate_conv_clock;
	end

	// Trigger edge detection and synchronisation delay
	logic trig_lvl;
	logic trig_edge;
	logic trig_ok;
	assign trig_lvl = trig_in[trigger_source_select];
	assign trig_ok = auto_trigger_enable && converter_enable
		&& trigger_source_select != TRIG_DONE_FLAG;
	// RL8: edges while busy are dropped
	// RL9: a still-set source flag gives no new edge
	assign trig_edge = trig_ok && trig_lvl && !trig_prev && state == SACC_IDLE
		&& !start_req && trig_pipe == '0;
	assign pre_reset = trig_pipe[TRIG_SYNC_CYC-1];

	// RL17: three mclk cycles of synchronisation before the prescaler reset
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			trig_prev <= 1'b0;
			trig_pipe <= '0;
		end
		else
		begin
			trig_prev <= trig_lvl;
			trig_pipe <= {trig_pipe[TRIG_SYNC_CYC-2:0], trig_edge};
		end
	end

	// Conversion length and completion
	logic is_diff;
	logic free_run;
	logic finish;
	logic begin_conv;
	assign is_diff = held_sel.channel[IS_DIFF];
	assign free_run = auto_trigger_enable && trigger_source_select == TRIG_DONE_FLAG;
	// Count rises since the start: whole cycles end on a rise, auto starts end half a cycle late
	assign finish = state == SACC_CONV && (conv_auto ? (fall && conv_cnt == conv_len)
		: (rise && conv_cnt == conv_len - 5'h1));
	// RL13: start waits for a rising converter clock edge
	assign begin_conv = state == SACC_IDLE && start_req && rise;

	// RL14: first conversion after enable is the long one
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			first_pend <= 1'b1;
		else if (!converter_enable)
			first_pend <= 1'b1;
		else if (begin_conv)
			first_pend <= 1'b0;
	end

	// Conversion sequencer
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			state <= SACC_IDLE;
			conv_cnt <= 5'h0;
			conv_len <= CYC_NORMAL;
			conv_first <= 1'b0;
			conv_auto <= 1'b0;
		end
		else if (!converter_enable)
			state <= SACC_IDLE;
		else if (begin_conv)
		begin
			state <= SACC_CONV;
			conv_cnt <= 5'h0;
			conv_first <= first_pend;
			conv_auto <= pre_reset_seen;
			// RL20: user start while half-rate clock high adds a cycle
			if (first_pend)
				conv_len <= CYC_FIRST;
			else if (is_diff && half_rate_conv_clock)
				conv_len <= CYC_DIFF_LONG;
			else
				conv_len <= CYC_NORMAL;
		end
		else if (finish)
		begin
			// RL18: free running restarts immediately
			// RL10: regardless of the done flag state
			if (free_run && !conv_auto)
			begin
				conv_cnt <= 5'h0;
				conv_first <= 1'b0;
				// RL20: automatic restarts on a differential channel always take the long form
				conv_len <= is_diff ? CYC_DIFF_LONG : CYC_NORMAL;
			end
			else
				state <= SACC_IDLE;
		end
		else if (state == SACC_CONV && rise)
			conv_cnt <= conv_cnt + 5'h1;
	end

	// Remember that the pending start came from a trigger
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			pre_reset_seen <= 1'b0;
		else if (pre_reset)
			pre_reset_seen <= 1'b1;
		else if (begin_conv || !converter_enable)
			pre_reset_seen <= 1'b0;
	end

	// Start request and visible start bit
	logic sw_start;
	assign sw_start = wr_a && pwdata[CA_START] && pwdata[CA_ENABLE];
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			start_req <= 1'b0;
		else if (!converter_enable && !(wr_a && pwdata[CA_ENABLE]))
			start_req <= 1'b0;
		// RL7: trigger edge starts a conversion
		// RL19: software start honoured in auto mode too
		else if (sw_start || pre_reset)
			start_req <= 1'b1;
		else if (begin_conv)
			start_req <= 1'b0;
	end

	// RL5: start bit reads one for the whole conversion
	// RL16: cleared in the completion cycle for single mode
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			start_conversion_bit <= 1'b0;
		else if (!converter_enable && !(wr_a && pwdata[CA_ENABLE]))
			start_conversion_bit <= 1'b0;
		else if (sw_start || pre_reset)
			start_conversion_bit <= 1'b1;
		else if (finish && !(free_run && !conv_auto))
			start_conversion_bit <= 1'b0;
	end

	// Control fields written by software
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			converter_enable <= RST_CTRL_A[CA_ENABLE];
			auto_trigger_enable <= RST_CTRL_A[CA_AUTO];
			clock_divider_select <= RST_CTRL_A[CA_DIV_LSB +: 3];
			trigger_source_select <= RST_CTRL_B;
			input_select_reg <= RST_INSEL;
		end
		else
		begin
			if (wr_a)
			begin
				converter_enable <= pwdata[CA_ENABLE];
				auto_trigger_enable <= pwdata[CA_AUTO];
				clock_divider_select <= pwdata[CA_DIV_LSB +: 3];
			end
			if (wr_b)
				trigger_source_select <= pwdata[CB_TRIG_LSB +: 3];
			if (wr_sel)
				input_select_reg <= pwdata[7:0];
		end
	end

	// RL4: flag sets on every completion; set beats the write-one clear
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			conversion_done_flag <= 1'b0;
		else if (finish)
			conversion_done_flag <= 1'b1;
		else if (wr_a && pwdata[CA_DONE])
			conversion_done_flag <= 1'b0;
	end

	// RL3: lock between low-byte and high-byte reads
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			res_lock <= 1'b0;
		else if (rd_high)
			res_lock <= 1'b0;
		else if (rd_low)
			res_lock <= 1'b1;
	end

	// RL2: result placed by the left-adjust select bit
	// RL3: a locked pair is left untouched
	logic [15:0] placed;
	assign placed = sacc_place(core_result, input_select_reg[IS_LEFT]);
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			result_high_byte <= 8'h0;
			result_low_byte <= 8'h0;
		end
		else if (finish && !res_lock)
		begin
			result_high_byte <= placed[15:8];
			result_low_byte <= placed[7:0];
		end
	end

	// RL22: holding copy tracks when idle or in the last cycle
	// RL6: a mid-conversion change waits for the end
	// RL1: nothing reaches the core while disabled
	logic last_cyc;
	assign last_cyc = state == SACC_CONV && conv_cnt == conv_len - 5'h1;
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			held_sel <= '0;
		else if (converter_enable && (state == SACC_IDLE || last_cyc))
		begin
			held_sel.ref_sel <= input_select_reg[IS_REF_LSB +: 2];
			held_sel.channel <= input_select_reg[IS_CHAN_LSB +: 5];
		end
	end

	// RL15: sample strobe at 1.5 cycles, 13.5 on the first
	// RL17: three cycles after the starting rise for auto starts
	logic sh_now;
	assign sh_now = state == SACC_CONV && (conv_auto ? (rise && conv_cnt == SH_AUTO)
		: (fall && conv_cnt == (conv_first ? SH_FIRST : SH_NORMAL)));

	// Core-facing outputs registered
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			core_ctl <= '0;
			core_sel <= '0;
			conv_done_irq <= 1'b0;
		end
		else
		begin
			core_ctl.active <= state == SACC_CONV;
			core_ctl.sample_hold <= sh_now;
			core_ctl.conv_clock <= converter_enable && pre_cnt < half;
			core_ctl.half_rate_conv_clock <= half_rate_conv_clock;
			core_sel <= held_sel;
			conv_done_irq <= finish;
		end
	end

	// Checks
	a_done_sets_flag: assert property (@(posedge mclk) disable iff (!nrst) // RL4
		finish |=> conversion_done_flag)
		else $error("done flag not set after completion");
	a_lock_holds_res: assert property (@(posedge mclk) disable iff (!nrst) // RL3
		(res_lock && !rd_high) |=> $stable(result_low_byte) && $stable(result_high_byte))
		else $error("result changed while locked");
	a_single_clears_start: assert property (@(posedge mclk) disable iff (!nrst) // RL16
		(finish && !free_run && !sw_start && !pre_reset) |=> !start_conversion_bit)
		else $error("start bit not cleared at single completion");
	a_busy_reads_start: assert property (@(posedge mclk) disable iff (!nrst) // RL5
		state == SACC_CONV |-> start_conversion_bit)
		else $error("start bit low during conversion");
	a_disable_holds_pre: assert property (@(posedge mclk) disable iff (!nrst) // RL11
		!converter_enable |=> pre_cnt == 8'h0)
		else $error("prescaler ran while disabled");
	a_first_len_long: assert property (@(posedge mclk) disable iff (!nrst) // RL14
		(begin_conv && first_pend) |=> conv_len == CYC_FIRST)
		else $error("first conversion not 25 cycles");
	a_sel_locked_conv: assert property (@(posedge mclk) disable iff (!nrst) // RL22
		(state == SACC_CONV && $past(state) == SACC_CONV && !$past(last_cyc))
		|-> $stable(held_sel))
		else $error("selection changed mid conversion");
	a_free_run_restart: assert property (@(posedge mclk) disable iff (!nrst) // RL18
		(finish && free_run && !conv_auto) |=> state == SACC_CONV && start_conversion_bit)
		else $error("free running did not restart");
	a_trig_reset_pre: assert property (@(posedge mclk) disable iff (!nrst) // RL7
		trig_edge |-> ##3 (pre_reset && converter_enable) ##1 start_req)
		else $error("trigger did not reset prescaler and request");
	a_start_on_rise: assert property (@(posedge mclk) disable iff (!nrst) // RL13
		($rose(state == SACC_CONV)) |-> $past(rise))
		else $error("conversion began off a rising edge");
	a_diff_restart_14: assert property (@(posedge mclk) disable iff (!nrst) // RL20
		(finish && free_run && !conv_auto && is_diff) |=> conv_len == CYC_DIFF_LONG)
		else $error("differential restart not 14 cycles");
	a_disabled_no_sel: assert property (@(posedge mclk) disable iff (!nrst) // RL1
		!converter_enable |=> $stable(held_sel))
		else $error("selection applied while disabled");

	c_single_done: cover property (@(posedge mclk) disable iff (!nrst)
		finish && !free_run);
	c_lock_drop: cover property (@(posedge mclk) disable iff (!nrst)
		finish && res_lock);
	c_auto_start: cover property (@(posedge mclk) disable iff (!nrst)
		pre_reset ##[1:300] begin_conv);
	c_free_run: cover property (@(posedge mclk) disable iff (!nrst)
		finish && free_run);
endmodule : sacc_ctrl

// ### bench/sacc_core_model.sv
// Behavioural analog core that answers each sample strobe with a channel-coded result
`timescale 1ns/1ps
module sacc_core_model
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// From the control block
	input wire sacc_pkg::sacc_sel_s core_sel,
	input wire sacc_pkg::sacc_core_s core_ctl,
	// Result towards the control block
	output logic [9:0] core_result
);
	import sacc_pkg::*;

	// Latch the held channel at the strobe, so a selection that slips through shows up
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			core_result <= 10'h2aa;
		else if (core_ctl.sample_hold)
			core_result <= {3'h5, core_sel.channel, 2'h2};
	end
endmodule : sacc_core_model

// ### bench/sacc_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sacc_ctrl_tb;
	import sacc_pkg::*;

	// One register access beside its expected answer
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic err;
	} sacc_row_s;

	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] trig_in = 8'h00;
	logic [9:0] core_result;
	sacc_sel_s core_sel;
	sacc_core_s core_ctl;
	logic conv_done_irq;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int irq_count = 0;
	int irq_cyc = 0;
	int prev_irq_cyc = 0;
	int t0;
	int k;
	logic [31:0] q;
	logic e;
	logic [9:0] r;
	sacc_row_s rows [11];

	// 100 MHz clock
	always #5 mclk = ~mclk;

	sacc_ctrl #(.NUM_TRIG(8), .RES_W(10)) sacc_ctrl_inst
	(
		.mclk(mclk),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.trig_in(trig_in),
		.core_result(core_result),
		.core_sel(core_sel),
		.core_ctl(core_ctl),
		.conv_done_irq(conv_done_irq)
	);

	sacc_core_model sacc_core_model_inst
	(
		.mclk(mclk),
		.nrst(nrst),
		.core_sel(core_sel),
		.core_ctl(core_ctl),
		.core_result(core_result)
	);

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	// Cycle count, completion stamps and the hang limit
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (conv_done_irq === 1'b1)
		begin
			irq_count <= irq_count + 1;
			prev_irq_cyc <= irq_cyc;
			irq_cyc <= cyc;
		end
		if (cyc >= 5000)
		begin
			err_count++;
			close_out();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Durations may land anywhere in a window, since converter clock phase is not fixed
	task automatic check_rng(input string nm, input int n, input int lo, input int hi);
		check(nm, n, (n >= lo && n <= hi) ? n : lo);
	endtask : check_rng

	// One APB transfer; waits for pready rather than assuming the wait state count
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
			err_count++;
	endtask : apb

	task automatic wait_irq(input int target);
		int n;
		n = 0;
		while (irq_count < target && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		if (n >= 400)
			err_count++;
	endtask : wait_irq

	function automatic logic [9:0] res_of(input logic [4:0] ch);
		return {3'h5, ch, 2'h2};
	endfunction : res_of

	// Main sequence
	initial
	begin
		rows[0] = '{1'b0, OFF_CTRL_A, 32'h0, {24'h0, RST_CTRL_A}, 1'b0};
		rows[1] = '{1'b0, OFF_CTRL_B, 32'h0, {29'h0, RST_CTRL_B}, 1'b0};
		rows[2] = '{1'b0, OFF_INSEL, 32'h0, {24'h0, RST_INSEL}, 1'b0};
		rows[3] = '{1'b1, OFF_INSEL, 32'hc5, 32'h0, 1'b0};
		rows[4] = '{1'b0, OFF_INSEL, 32'h0, 32'hc5, 1'b0};
		rows[5] = '{1'b1, OFF_CTRL_B, 32'h7, 32'h0, 1'b0};
		rows[6] = '{1'b0, OFF_CTRL_B, 32'h0, 32'h7, 1'b0};
		rows[7] = '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1};
		rows[8] = '{1'b1, 8'h14, 32'hff, 32'h0, 1'b1};
		rows[9] = '{1'b1, OFF_CTRL_A, 32'h07, 32'h0, 1'b0};
		rows[10] = '{1'b0, OFF_CTRL_A, 32'h0, 32'h07, 1'b0};
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			check("slverr", {31'h0, e}, {31'h0, rows[i].err});
			if (!rows[i].wr)
				check("readback", q, rows[i].exp);
		end
		check("sel while off", {25'h0, core_sel}, 32'h0);
		// First conversion after enabling, right adjusted
		apb(1'b1, OFF_INSEL, 32'h05);
		apb(1'b1, OFF_CTRL_A, 32'hc0);
		t0 = cyc;
		apb(1'b0, OFF_CTRL_A, 32'h0);
		check("busy", {30'h0, q[7:6]}, 32'h3);
		wait_irq(1);
		check_rng("first len", irq_cyc - t0, 48, 56);
		check("sel on", {25'h0, core_sel}, 32'h05);
		apb(1'b0, OFF_CTRL_A, 32'h0);
		check("done", {28'h0, q[7:4]}, 32'h9);
		r = res_of(5'h05);
		apb(1'b0, OFF_RES_LOW, 32'h0);
		check("low", q, {24'h0, r[7:0]});
		apb(1'b0, OFF_RES_HIGH, 32'h0);
		check("high", q, {30'h0, r[9:8]});
		// Normal conversion, left adjusted, channel moved mid-conversion
		apb(1'b1, OFF_INSEL, 32'h23);
		apb(1'b1, OFF_CTRL_A, 32'hd0);
		t0 = cyc;
		apb(1'b1, OFF_INSEL, 32'h2a);
		wait_irq(2);
		check_rng("normal len", irq_cyc - t0, 24, 32);
		r = res_of(5'h03);
		apb(1'b0, OFF_RES_LOW, 32'h0);
		check("left low", q, {24'h0, r[1:0], 6'h0});
		apb(1'b0, OFF_RES_HIGH, 32'h0);
		check("left high", q, {24'h0, r[9:2]});
		// Low byte read locks out the next result
		apb(1'b0, OFF_RES_LOW, 32'h0);
		apb(1'b1, OFF_CTRL_A, 32'hd0);
		wait_irq(3);
		apb(1'b0, OFF_CTRL_A, 32'h0);
		check("done kept", {31'h0, q[4]}, 32'h1);
		apb(1'b0, OFF_RES_HIGH, 32'h0);
		check("locked high", q, {24'h0, r[9:2]});
		apb(1'b0, OFF_RES_LOW, 32'h0);
		check("locked low", q, {24'h0, r[1:0], 6'h0});
		// Auto trigger on source 2; a held level and another source start nothing
		apb(1'b1, OFF_CTRL_B, 32'h2);
		apb(1'b1, OFF_CTRL_A, 32'hb0);
		trig_in <= 8'h04;
		t0 = cyc;
		wait_irq(4);
		check_rng("auto len", irq_cyc - t0, 27, 36);
		trig_in <= 8'h0c;
		repeat (80) @(posedge mclk);
		check("held trig", irq_count, 4);
		// source drops before its next event
		trig_in <= 8'h00;
		apb(1'b1, OFF_CTRL_A, 32'hf0);
		repeat (4) @(posedge mclk);
		trig_in <= 8'h04;
		wait_irq(5);
		repeat (80) @(posedge mclk);
		check("edge in conv", irq_count, 5);
		trig_in <= 8'h00;
		// Free running from the done flag, flag cleared only by the starting write
		apb(1'b1, OFF_CTRL_B, 32'h0);
		apb(1'b1, OFF_CTRL_A, 32'hf0);
		wait_irq(8);
		check_rng("free gap", irq_cyc - prev_irq_cyc, 26, 28);
		apb(1'b0, OFF_CTRL_A, 32'h0);
		check("free busy", {30'h0, q[6], q[4]}, 32'h3);
		// Differential channel while free running: automatic restarts take 14 cycles
		apb(1'b1, OFF_INSEL, 32'h30);
		wait_irq(irq_count + 4);
		check("diff gap", irq_cyc - prev_irq_cyc, 28);
		// enable toggled so the next start is the extended one
		apb(1'b1, OFF_CTRL_A, 32'h00);
		// Let a completion pulse from the disabling edge be counted first
		repeat (2) @(posedge mclk);
		k = irq_count;
		repeat (100) @(posedge mclk);
		check("stopped", irq_count, k);
		check("inactive", {31'h0, core_ctl.active}, 32'h0);
		apb(1'b0, OFF_CTRL_A, 32'h0);
		check("idle", {30'h0, q[7:6]}, 32'h0);
		apb(1'b1, OFF_CTRL_A, 32'hc0);
		t0 = cyc;
		wait_irq(k + 1);
		check_rng("reenable len", irq_cyc - t0, 48, 56);
		close_out();
	end
endmodule : sacc_ctrl_tb
